// ---- design/vrs_map.svh ----
`ifndef VRS_MAP_SVH
`define VRS_MAP_SVH

// Word indices of the register file; byte address is four times the index
`define VRS_REG_MODE         6'h00
`define VRS_REG_CTRL         6'h01
`define VRS_REG_STATUS       6'h02
`define VRS_REG_VL_TARGET    6'h03
`define VRS_REG_VL_MIN       6'h04
`define VRS_REG_VL_MAX       6'h05
`define VRS_REG_VL_ACC_DV    6'h06
`define VRS_REG_VL_ACC_DT    6'h07
`define VRS_REG_VL_DEC_DV    6'h08
`define VRS_REG_VL_DEC_DT    6'h09
`define VRS_REG_VL_QS_DV     6'h0A
`define VRS_REG_VL_QS_DT     6'h0B
`define VRS_REG_DIM_MUL      6'h0C
`define VRS_REG_DIM_DIV      6'h0D
`define VRS_REG_VL_DEMAND    6'h0E
`define VRS_REG_VL_ACTUAL    6'h0F
`define VRS_REG_PV_TARGET    6'h10
`define VRS_REG_POLARITY     6'h11
`define VRS_REG_PROF_ACC     6'h12
`define VRS_REG_PROF_DEC     6'h13
`define VRS_REG_QS_DEC       6'h14
`define VRS_REG_RAMP_TYPE    6'h15
`define VRS_REG_JERK1        6'h16
`define VRS_REG_JERK2        6'h17
`define VRS_REG_JERK3        6'h18
`define VRS_REG_JERK4        6'h19
`define VRS_REG_MAX_ACC      6'h1A
`define VRS_REG_MAX_DEC      6'h1B
`define VRS_REG_MAX_PROF_VEL 6'h1C
`define VRS_REG_MAX_MOTOR    6'h1D
`define VRS_REG_VEL_WIN      6'h1E
`define VRS_REG_VEL_WIN_TIME 6'h1F
`define VRS_REG_THRESH       6'h20
`define VRS_REG_THRESH_TIME  6'h21
`define VRS_REG_MAX_SLIP     6'h22
`define VRS_REG_SLIP_TIME    6'h23
`define VRS_REG_POS_MIN      6'h24
`define VRS_REG_POS_MAX      6'h25
`define VRS_REG_DEMAND       6'h26
`define VRS_REG_ACTUAL       6'h27
`define VRS_REG_POSITION     6'h28
`define VRS_NUM_REGS         6'h29

// Codes and field positions
`define VRS_MODE_VL          8'h02
`define VRS_MODE_PV          8'h03
`define VRS_RAMP_JERK        8'h03
`define VRS_CTRL_ENABLE      0
`define VRS_CTRL_CLOSED      1
`define VRS_CTRL_QSTOP       2
`define VRS_CTRL_HALT        8
`define VRS_POL_SPEED        6
`define VRS_ST_HALT          8
`define VRS_ST_REACHED       10
`define VRS_ST_LIMIT         11
`define VRS_ST_ZERO          12
`define VRS_ST_SLIP          13

// Reset values
`define VRS_RST_ZERO         32'h00000000
`define VRS_RST_ONE          32'h00000001
`define VRS_RST_MAX          32'h7FFFFFFF
`define VRS_RST_RAMP         32'h00000000

// Timing
`define VRS_CLK_NS           10
`define VRS_RAMP_TICK_NS     1000
`define VRS_MS_NS            1000000
`define VRS_S_NS             1000000000
`define VRS_MS_PER_S         33'h0000003E8

`endif

// ---- design/vrs_pkg.sv ----
`default_nettype none

package vrs_pkg;

	typedef logic signed [31:0] vrs_speed_t;

	typedef enum logic [1:0] {
		PH_OFF,
		PH_TRACK,
		PH_HALT,
		PH_QSTOP
	} vrs_phase_t;

endpackage

`default_nettype wire

// ---- design/vrs_persist.sv ----
`timescale 1ns/1ps
`default_nettype none

// Raises hold once cond has stood unbroken for limit millisecond ticks
module vrs_persist #(
	parameter int W = 32
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         tick,
	input  wire logic         cond,
	input  wire logic [W-1:0] limit,
	output logic              hold
);
	logic [W-1:0] cnt;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt  <= '0;
			hold <= 1'b0;
		end else if (!cond) begin
			cnt  <= '0;
			hold <= 1'b0;
		end else if (cnt >= limit) begin
			hold <= 1'b1;
		end else if (tick) begin
			cnt <= cnt + 1'b1;
		end
	end

endmodule

`default_nettype wire

// ---- design/vrs_rate.sv ----
`timescale 1ns/1ps
`default_nettype none

// Fractional rate generator: delta units per secs seconds, one step per tick at most
module vrs_rate #(
	parameter int TICKS_PER_S = 1000000
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        tick,
	input  wire logic        clear,
	input  wire logic [31:0] delta,
	input  wire logic [15:0] secs,
	output logic             step
);
	logic [47:0] den;
	logic [47:0] acc;
	logic [47:0] sum;
	logic [47:0] rest;

	assign den  = 48'((secs == 16'h0000) ? 16'h0001 : secs) * 48'(TICKS_PER_S);
	assign sum  = acc + {16'h0000, delta};
	assign rest = sum - den;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc  <= '0;
			step <= 1'b0;
		end else begin
			step <= 1'b0;
			if (clear) begin
				acc <= '0;
			end else if (tick) begin
				if (sum >= den) begin
					step <= 1'b1;
					// Saturate: excess rate beyond one step per tick is dropped
					acc  <= (rest >= den) ? 48'h0 : rest;
				end else begin
					acc <= sum;
				end
			end
		end
	end

endmodule

`default_nettype wire

// ---- design/vrs_ctrl.sv ----
// Operation
// (RL1) Mode code 2 selects plain velocity
// (RL2) Mode code 3 selects profile velocity
// (RL3) Ramp type 0 trapezoid, 3 uses jerks
// (RL4) Ramp type resets to trapezoid
// (RL5) Speed capped by smaller velocity ceiling
// (RL6) Velocity halt: edges brake or accelerate
// (RL7) Velocity bit 11 while limit constrains
// (RL8) Velocity readback scaled multiplier over divisor
// (RL9) Velocity acceleration is delta over seconds
// (RL10) Software gives deceleration as positive delta
// (RL11) Target below minimum uses minimum
// (RL12) Target above maximum uses maximum
// (RL13) Velocity quick stop has own ramp
// (RL14) Ramp tracks target; demand, actual readable
// (RL15) Plain velocity never limits jerk
// (RL16) Profile halt: edges start or brake
// (RL17) Bit 10 with halt gives four states
// (RL18) Bit 12 clears above threshold for time
// (RL19) Bit 13 on slippage past timeout
// (RL20) Position wraps within range limits
// (RL21) Quick-stop state uses quick-stop deceleration
// (RL22) Ramps never exceed max accel, decel
// (RL23) Polarity bit 6 inverts target speed
// (RL24) Reached needs window held for time
// (RL25) Halt edges from previous halt sample
//
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "vrs_map.svh"

module vrs_ctrl #(
	parameter int MS_CYCLES   = `VRS_MS_NS / `VRS_CLK_NS,
	parameter int RAMP_CYCLES = `VRS_RAMP_TICK_NS / `VRS_CLK_NS
) (
	input  wire logic               CORE_CLK,
	input  wire logic               RST,
	input  wire logic               WB_CYC_I,
	input  wire logic               WB_STB_I,
	input  wire logic               WB_WE_I,
	input  wire logic [7:0]         WB_ADR_I,
	input  wire logic [3:0]         WB_SEL_I,
	input  wire logic [31:0]        WB_DAT_I,
	output logic      [31:0]        WB_DAT_O,
	output logic                    WB_ACK_O,
	input  wire vrs_pkg::vrs_speed_t ACTUAL_SPEED,
	input  wire logic [31:0]        POSITION_IN,
	output vrs_pkg::vrs_speed_t     SPEED_DEMAND,
	output logic                    DRIVE_ENABLE
);
	import vrs_pkg::*;

	localparam int TICKS_PER_S = `VRS_S_NS / `VRS_RAMP_TICK_NS;
	localparam int RW          = $clog2(RAMP_CYCLES + 1);
	localparam int MW          = $clog2(MS_CYCLES + 1);

	function automatic logic [31:0] mag(input logic [31:0] v);
		return v[31] ? (~v + 32'h00000001) : v;
	endfunction

	function automatic logic [31:0] jstep(input logic [31:0] j);
		logic [32:0] t;
		t = {1'b0, j} + (`VRS_MS_PER_S - 33'h000000001);
		return 32'(t / `VRS_MS_PER_S);
	endfunction

	logic [31:0]  regs [0:`VRS_NUM_REGS-1];
	vrs_phase_t   phase;
	vrs_phase_t   next_phase;
	vrs_speed_t   demand;
	vrs_speed_t   position;
	logic [31:0]  pos_in_prev;
	logic [31:0]  acc_eff;
	logic [31:0]  next_acc_eff;
	logic         halt_prev;
	logic [RW-1:0] ramp_cnt;
	logic [MW-1:0] ms_cnt;
	logic [31:0]  status;

	// Bus decode
	logic [5:0]  idx;
	logic        take;
	logic        mapped;
	logic        is_ro;
	logic        wr_en;
	logic [31:0] rdata;

	assign idx    = WB_ADR_I[7:2];
	assign take   = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	assign mapped = idx < `VRS_NUM_REGS;
	assign is_ro  = (idx == `VRS_REG_STATUS) || (idx == `VRS_REG_VL_DEMAND) ||
	                (idx == `VRS_REG_VL_ACTUAL) || (idx == `VRS_REG_DEMAND) ||
	                (idx == `VRS_REG_ACTUAL) || (idx == `VRS_REG_POSITION);
	assign wr_en  = take & WB_WE_I & mapped & ~is_ro;

	// Fields
	logic [7:0]  mode;
	logic        is_vl;
	logic        is_pv;
	logic        enabled;
	logic        closed;
	logic        qstop;
	logic        halt;
	logic        halt_rise;
	logic        halt_fall;
	logic        ramp_tick;
	logic        ms_tick;

	assign mode      = regs[`VRS_REG_MODE][7:0];
	assign is_vl     = mode == `VRS_MODE_VL;                              // [RL1]
	assign is_pv     = mode == `VRS_MODE_PV;                              // [RL2]
	assign enabled   = regs[`VRS_REG_CTRL][`VRS_CTRL_ENABLE];
	assign closed    = regs[`VRS_REG_CTRL][`VRS_CTRL_CLOSED];
	assign qstop     = regs[`VRS_REG_CTRL][`VRS_CTRL_QSTOP];
	assign halt      = regs[`VRS_REG_CTRL][`VRS_CTRL_HALT];
	assign halt_rise = halt & ~halt_prev;                                 // [RL25]
	assign halt_fall = ~halt & halt_prev;                                 // [RL25]
	assign ramp_tick = ramp_cnt == RW'(RAMP_CYCLES - 1);
	assign ms_tick   = ms_cnt == MW'(MS_CYCLES - 1);

	// Effective target
	logic [31:0] vl_abs;
	logic        vl_lo;
	logic        vl_hi;
	logic [31:0] vl_mag;
	logic [31:0] pv_raw;
	logic [31:0] vcap;
	logic [31:0] sel_mag;
	logic        sel_neg;
	logic        cap_hit;
	logic [31:0] eff_mag;
	vrs_speed_t  eff_target;
	vrs_speed_t  goal;

	assign vl_abs  = mag(regs[`VRS_REG_VL_TARGET]);
	assign vl_lo   = vl_abs < regs[`VRS_REG_VL_MIN];                     // [RL11]
	assign vl_hi   = vl_abs > regs[`VRS_REG_VL_MAX];                     // [RL12]
	assign vl_mag  = vl_lo ? regs[`VRS_REG_VL_MIN] :
	                 vl_hi ? regs[`VRS_REG_VL_MAX] : vl_abs;             // [RL11] [RL12]
	assign pv_raw  = regs[`VRS_REG_POLARITY][`VRS_POL_SPEED] ?
	                 (~regs[`VRS_REG_PV_TARGET] + 32'h00000001) :
	                 regs[`VRS_REG_PV_TARGET];                           // [RL23]
	assign vcap    = (regs[`VRS_REG_MAX_PROF_VEL] < regs[`VRS_REG_MAX_MOTOR]) ?
	                 regs[`VRS_REG_MAX_PROF_VEL] : regs[`VRS_REG_MAX_MOTOR]; // [RL5]
	assign sel_mag = is_vl ? vl_mag : mag(pv_raw);
	assign sel_neg = is_vl ? regs[`VRS_REG_VL_TARGET][31] : pv_raw[31];
	assign cap_hit = sel_mag > vcap;                                     // [RL5]
	assign eff_mag = cap_hit ? vcap : sel_mag;
	assign eff_target = $signed(sel_neg ? (~eff_mag + 32'h00000001) : eff_mag);
	assign goal    = (phase == PH_TRACK) ? eff_target : '0;              // [RL14]

	// Ramp direction and rate selection
	logic        at_goal;
	logic        braking;
	logic        qs_on;
	logic [31:0] raw_num;
	logic [15:0] raw_secs;
	logic [15:0] secs_n;
	logic [31:0] acc_lim;
	logic [47:0] lim_prod;
	logic        acc_over;
	logic        acc_hit;
	logic [31:0] num_lim;
	logic [15:0] secs_lim;
	logic        jerk_on;
	logic [31:0] goal_rate;
	logic [31:0] step_up;
	logic [31:0] step_dn;
	logic [31:0] diff_up;
	logic [31:0] diff_dn;
	logic [31:0] rate_num;
	logic [15:0] rate_secs;
	logic        rate_step;

	assign at_goal  = demand == goal;
	assign braking  = (mag(goal) < mag(demand)) ||
	                  ((demand != '0) && (goal != '0) && (demand[31] != goal[31]));
	assign qs_on    = phase == PH_QSTOP;
	assign raw_num  = is_vl ?
	                  (qs_on   ? regs[`VRS_REG_VL_QS_DV]  :               // [RL13]
	                   braking ? regs[`VRS_REG_VL_DEC_DV] :               // [RL6] [RL10]
	                             regs[`VRS_REG_VL_ACC_DV]) :              // [RL9]
	                  (qs_on   ? regs[`VRS_REG_QS_DEC]   :                // [RL21]
	                   braking ? regs[`VRS_REG_PROF_DEC] :                // [RL16]
	                             regs[`VRS_REG_PROF_ACC]);                // [RL16]
	assign raw_secs = !is_vl ? 16'h0001 :
	                  qs_on   ? regs[`VRS_REG_VL_QS_DT][15:0]  :
	                  braking ? regs[`VRS_REG_VL_DEC_DT][15:0] :
	                            regs[`VRS_REG_VL_ACC_DT][15:0];           // [RL9]
	assign secs_n   = (raw_secs == 16'h0000) ? 16'h0001 : raw_secs;
	assign acc_lim  = (braking || qs_on) ? regs[`VRS_REG_MAX_DEC] : regs[`VRS_REG_MAX_ACC];
	assign lim_prod = 48'(acc_lim) * 48'(secs_n);
	assign acc_over = {16'h0000, raw_num} > lim_prod;                     // [RL22]
	assign num_lim  = acc_over ? acc_lim : raw_num;                       // [RL22]
	assign secs_lim = acc_over ? 16'h0001 : secs_n;
	assign acc_hit  = acc_over && !at_goal && (phase != PH_OFF);

	// Jerk: the working acceleration itself ramps toward the rate goal
	assign jerk_on   = is_pv && (regs[`VRS_REG_RAMP_TYPE][7:0] == `VRS_RAMP_JERK); // [RL3] [RL15]
	assign goal_rate = at_goal ? 32'h00000000 : num_lim;
	assign step_up   = jstep(braking ? regs[`VRS_REG_JERK3] : regs[`VRS_REG_JERK1]); // [RL3]
	assign step_dn   = jstep(braking ? regs[`VRS_REG_JERK4] : regs[`VRS_REG_JERK2]); // [RL3]
	assign diff_up   = goal_rate - acc_eff;
	assign diff_dn   = acc_eff - goal_rate;
	assign next_acc_eff = ((phase == PH_OFF) || !jerk_on) ? 32'h00000000 :
	                      !ms_tick ? acc_eff :
	                      (acc_eff < goal_rate) ?
	                          acc_eff + ((step_up < diff_up) ? step_up : diff_up) :
	                      (acc_eff > goal_rate) ?
	                          acc_eff - ((step_dn < diff_dn) ? step_dn : diff_dn) :
	                          acc_eff;
	assign rate_num  = jerk_on ? acc_eff : num_lim;                       // [RL3]
	assign rate_secs = jerk_on ? 16'h0001 : secs_lim;

	vrs_rate #(
		.TICKS_PER_S (TICKS_PER_S)
	) u_rate (
		.clk   (CORE_CLK),
		.rst   (RST),
		.tick  (ramp_tick),
		.clear (at_goal || (phase == PH_OFF)),
		.delta (rate_num),
		.secs  (rate_secs),
		.step  (rate_step)
	);

	// Operating phase
	always_comb begin
		next_phase = phase;
		if (!enabled || !(is_vl || is_pv)) begin
			next_phase = PH_OFF;
		end else if (qstop) begin
			next_phase = PH_QSTOP;                                            // [RL21]
		end else begin
			unique case (phase)
				PH_OFF: begin
					next_phase = halt ? PH_HALT : PH_TRACK;
				end
				PH_TRACK: begin
					if (halt_rise) begin
						next_phase = PH_HALT;                                     // [RL6] [RL16]
					end
				end
				PH_HALT: begin
					if (halt_fall) begin
						next_phase = PH_TRACK;                                    // [RL6] [RL16]
					end
				end
				PH_QSTOP: begin
					next_phase = halt ? PH_HALT : PH_TRACK;
				end
			endcase
		end
	end

	// Status and supervision
	logic [31:0] act_abs;
	logic        win_hold;
	logic        thr_hold;
	logic        slip_hold;
	logic        st_reached;
	logic        st_limit;

	assign act_abs = mag(ACTUAL_SPEED);

	vrs_persist #(
		.W (32)
	) u_win (
		.clk   (CORE_CLK),
		.rst   (RST),
		.tick  (ms_tick),
		.cond  (mag(eff_target - ACTUAL_SPEED) <= regs[`VRS_REG_VEL_WIN]), // [RL24]
		.limit (regs[`VRS_REG_VEL_WIN_TIME]),
		.hold  (win_hold)
	);

	vrs_persist #(
		.W (32)
	) u_thr (
		.clk   (CORE_CLK),
		.rst   (RST),
		.tick  (ms_tick),
		.cond  (act_abs > regs[`VRS_REG_THRESH]),                          // [RL18]
		.limit (regs[`VRS_REG_THRESH_TIME]),
		.hold  (thr_hold)
	);

	vrs_persist #(
		.W (32)
	) u_slip (
		.clk   (CORE_CLK),
		.rst   (RST),
		.tick  (ms_tick),
		.cond  (closed && (mag(demand - ACTUAL_SPEED) > regs[`VRS_REG_MAX_SLIP])), // [RL19]
		.limit (regs[`VRS_REG_SLIP_TIME]),
		.hold  (slip_hold)
	);

	assign st_reached = is_pv && (halt ? (demand == '0) : win_hold);       // [RL17]
	assign st_limit   = is_vl && (phase == PH_TRACK) &&
	                    (vl_lo || vl_hi || cap_hit || acc_hit);            // [RL7]

	always_comb begin
		status                  = 32'h00000000;
		status[`VRS_ST_HALT]    = halt;
		status[`VRS_ST_REACHED] = st_reached;                               // [RL17]
		status[`VRS_ST_LIMIT]   = st_limit;                                 // [RL7]
		status[`VRS_ST_ZERO]    = is_pv && !thr_hold;                       // [RL18]
		status[`VRS_ST_SLIP]    = slip_hold;                                // [RL19]
	end

	// Speed readback in user units
	logic signed [63:0] dem_prod;
	logic signed [63:0] act_prod;
	logic signed [63:0] dem_user;
	logic signed [63:0] act_user;
	logic signed [63:0] dim_div;

	assign dim_div  = $signed({32'h00000000, regs[`VRS_REG_DIM_DIV]});
	assign dem_prod = $signed({{32{demand[31]}}, demand}) *
	                  $signed({32'h00000000, regs[`VRS_REG_DIM_MUL]});
	assign act_prod = $signed({{32{ACTUAL_SPEED[31]}}, ACTUAL_SPEED}) *
	                  $signed({32'h00000000, regs[`VRS_REG_DIM_MUL]});
	assign dem_user = (dim_div == 64'sh0) ? 64'sh0 : dem_prod / dim_div;   // [RL8]
	assign act_user = (dim_div == 64'sh0) ? 64'sh0 : act_prod / dim_div;   // [RL8]

	// Modulo position
	logic signed [31:0] pos_sum;
	logic signed [31:0] pos_min;
	logic signed [31:0] pos_max;
	logic signed [31:0] pos_range;
	logic signed [31:0] next_position;

	assign pos_min   = $signed(regs[`VRS_REG_POS_MIN]);
	assign pos_max   = $signed(regs[`VRS_REG_POS_MAX]);
	assign pos_range = pos_max - pos_min + 32'sh1;
	assign pos_sum   = position + $signed(POSITION_IN - pos_in_prev);
	assign next_position = (pos_max <= pos_min) ? pos_sum :
	                       (pos_sum > pos_max) ? pos_sum - pos_range :     // [RL20]
	                       (pos_sum < pos_min) ? pos_sum + pos_range :     // [RL20]
	                       pos_sum;

	assign rdata = !mapped ? 32'h00000000 :
	               (idx == `VRS_REG_STATUS)    ? status :
	               (idx == `VRS_REG_VL_DEMAND) ? dem_user[31:0] :          // [RL8]
	               (idx == `VRS_REG_VL_ACTUAL) ? act_user[31:0] :
	               (idx == `VRS_REG_DEMAND)    ? demand :                  // [RL14]
	               (idx == `VRS_REG_ACTUAL)    ? ACTUAL_SPEED :            // [RL14]
	               (idx == `VRS_REG_POSITION)  ? position :
	               regs[idx];

	// Register file
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			for (int i = 0; i < `VRS_NUM_REGS; i++) begin
				regs[i] <= `VRS_RST_ZERO;
			end
			regs[`VRS_REG_RAMP_TYPE]    <= `VRS_RST_RAMP;                    // [RL4]
			regs[`VRS_REG_VL_MAX]       <= `VRS_RST_MAX;
			regs[`VRS_REG_VL_ACC_DT]    <= `VRS_RST_ONE;
			regs[`VRS_REG_VL_DEC_DT]    <= `VRS_RST_ONE;
			regs[`VRS_REG_VL_QS_DT]     <= `VRS_RST_ONE;
			regs[`VRS_REG_DIM_MUL]      <= `VRS_RST_ONE;
			regs[`VRS_REG_DIM_DIV]      <= `VRS_RST_ONE;
			regs[`VRS_REG_MAX_ACC]      <= `VRS_RST_MAX;
			regs[`VRS_REG_MAX_DEC]      <= `VRS_RST_MAX;
			regs[`VRS_REG_MAX_PROF_VEL] <= `VRS_RST_MAX;
			regs[`VRS_REG_MAX_MOTOR]    <= `VRS_RST_MAX;
		end else if (wr_en) begin
			for (int b = 0; b < 4; b++) begin
				if (WB_SEL_I[b]) begin
					regs[idx][8*b +: 8] <= WB_DAT_I[8*b +: 8];
				end
			end
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h00000000;
		end else begin
			WB_ACK_O <= take;
			if (take) begin
				WB_DAT_O <= rdata;
			end
		end
	end

	// Tick prescalers
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			ramp_cnt <= '0;
			ms_cnt   <= '0;
		end else begin
			ramp_cnt <= ramp_tick ? '0 : ramp_cnt + 1'b1;
			ms_cnt   <= ms_tick ? '0 : ms_cnt + 1'b1;
		end
	end

	// Ramp state
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			phase     <= PH_OFF;
			halt_prev <= 1'b0;
			acc_eff   <= 32'h00000000;
			demand    <= '0;
		end else begin
			phase     <= next_phase;
			halt_prev <= halt;                                              // [RL25]
			acc_eff   <= next_acc_eff;
			if (phase == PH_OFF) begin
				demand <= '0;
			end else if (rate_step && !at_goal) begin
				demand <= (goal > demand) ? demand + 32'sh1 : demand - 32'sh1; // [RL14]
			end
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			position     <= '0;
			pos_in_prev  <= 32'h00000000;
			SPEED_DEMAND <= '0;
			DRIVE_ENABLE <= 1'b0;
		end else begin
			position     <= next_position;
			pos_in_prev  <= POSITION_IN;
			SPEED_DEMAND <= demand;
			DRIVE_ENABLE <= next_phase != PH_OFF;
		end
	end

endmodule

`default_nettype wire

// ---- dv/vrs_ctrl_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "vrs_map.svh"

module vrs_ctrl_chk #(
	parameter int MS_CYCLES   = 10,
	parameter int RAMP_CYCLES = 4
) (
	input wire logic                CORE_CLK,
	input wire logic                RST,
	input wire logic                WB_CYC_I,
	input wire logic                WB_STB_I,
	input wire logic                WB_WE_I,
	input wire logic [7:0]          WB_ADR_I,
	input wire logic [3:0]          WB_SEL_I,
	input wire logic [31:0]         WB_DAT_I,
	input wire logic [31:0]         WB_DAT_O,
	input wire logic                WB_ACK_O,
	input wire vrs_pkg::vrs_speed_t ACTUAL_SPEED,
	input wire logic [31:0]         POSITION_IN,
	input wire vrs_pkg::vrs_speed_t SPEED_DEMAND,
	input wire logic                DRIVE_ENABLE
);
	import vrs_pkg::*;
	logic        req;
	logic        wr;
	logic        halt_q;
	logic [2:0]  age;
	logic [31:0] mag;
	assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	assign wr  = req && WB_WE_I && WB_SEL_I == 4'hF;
	assign mag = SPEED_DEMAND[31] ? -SPEED_DEMAND : SPEED_DEMAND;
	// Halt shadow, aged past the control-to-output latency
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			halt_q <= 1'b0;
			age    <= 3'h0;
		end else if (wr && WB_ADR_I[7:2] == `VRS_REG_CTRL) begin
			halt_q <= WB_DAT_I[8];
			age    <= 3'h0;
		end else if (age != 3'h7) begin
			age <= age + 3'h1;
		end
	end
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	chk_req_acked: assert property (req |=> WB_ACK_O)
		else $error("ack missing after request");
	chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	chk_unmapped_zero: assert property ((req && !WB_WE_I
		&& WB_ADR_I[7:2] >= `VRS_NUM_REGS) |=> WB_DAT_O == 32'h0)
		else $error("unmapped read not zero");
	chk_step_unit: assert property (($changed(SPEED_DEMAND)
		&& SPEED_DEMAND != 0) |->
		(SPEED_DEMAND - $past(SPEED_DEMAND) == 1 || $past(SPEED_DEMAND) - SPEED_DEMAND == 1))
		else $error("demand step not one unit");
	chk_step_spacing: assert property (($changed(SPEED_DEMAND)
		&& SPEED_DEMAND != 0) |=>
		(SPEED_DEMAND == $past(SPEED_DEMAND) || SPEED_DEMAND == 0) [*3])
		else $error("demand steps too close");
	chk_off_zero: assert property (!DRIVE_ENABLE [*3] |-> SPEED_DEMAND == 0)
		else $error("demand while disabled");
	chk_halt_brakes: assert property ((halt_q && age == 3'h7
		&& $changed(SPEED_DEMAND)) |-> mag < $past(mag))
		else $error("speed rises while halted");
	chk_enable_drop: assert property ((wr && WB_ADR_I[7:2] == `VRS_REG_CTRL
		&& !WB_DAT_I[0]) |-> ##[1:6] !DRIVE_ENABLE)
		else $error("drive stays enabled");
	chk_mode_off: assert property ((wr && WB_ADR_I[7:2] == `VRS_REG_MODE
		&& WB_DAT_I[7:0] != `VRS_MODE_VL && WB_DAT_I[7:0] != `VRS_MODE_PV)
		|-> ##[1:6] !DRIVE_ENABLE)
		else $error("drive on in other mode");
endmodule

bind vrs_ctrl vrs_ctrl_chk #(.MS_CYCLES(MS_CYCLES), .RAMP_CYCLES(RAMP_CYCLES)) u_chk (
	.CORE_CLK(CORE_CLK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
	.WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
	.WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .ACTUAL_SPEED(ACTUAL_SPEED),
	.POSITION_IN(POSITION_IN), .SPEED_DEMAND(SPEED_DEMAND), .DRIVE_ENABLE(DRIVE_ENABLE));

`default_nettype wire

// ---- dv/vrs_motor.sv ----
`timescale 1ns/1ps
`default_nettype none

module vrs_motor (
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic                slow,
	input  wire vrs_pkg::vrs_speed_t demand,
	output vrs_pkg::vrs_speed_t      speed,
	output logic [31:0]              pos
);
	import vrs_pkg::*;
	// Follows demand a clock late; a stalled rotor keeps its speed
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			speed <= '0;
			pos   <= 32'h0;
		end else begin
			if (!slow)
				speed <= demand;
			pos <= pos + speed;
		end
	end
endmodule

`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "vrs_map.svh"

module tb;
	import vrs_pkg::*;
	logic        clk = 0;
	logic        rst = 1;
	logic        cyc = 0;
	logic        stb = 0;
	logic        we = 0;
	logic        slow = 0;
	logic        ack;
	logic        den;
	logic [7:0]  adr = 8'h0;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] pos;
	logic [31:0] d;
	vrs_speed_t  act;
	vrs_speed_t  dem;
	int          bad_count = 0;
	int          compares = 0;
	int          cycles = 0;
	always #5 clk = ~clk;
	vrs_ctrl #(.MS_CYCLES(10), .RAMP_CYCLES(4)) u_vrs_ctrl (
		.CORE_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.ACTUAL_SPEED(act), .POSITION_IN(pos), .SPEED_DEMAND(dem), .DRIVE_ENABLE(den));
	vrs_motor u_vrs_motor (.clk(clk), .rst(rst), .slow(slow), .demand(dem), .speed(act),
		.pos(pos));

	task automatic end_of_test;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 100000) begin
			bad_count++;
			end_of_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] v,
		output logic [31:0] r);
		@(posedge clk);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= {a, 2'b00};
		sel  <= 4'hF;
		wdat <= v;
		@(posedge clk);
		while (ack !== 1'b1)
			@(posedge clk);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] v);
		bus(1'b1, a, v, d);
	endtask
	task automatic wait_reg(input logic [5:0] a, input logic [31:0] e);
		for (int n = 0; n < 400; n++) begin
			bus(1'b0, a, 32'h0, d);
			if (d === e)
				break;
		end
		chk(d, e);
	endtask
	function automatic logic [31:0] rst_val(input int i);
		if (i == 5 || (i >= 26 && i <= 29))
			return 32'h7FFFFFFF;
		if (i == 7 || i == 9 || i == 11 || i == 12 || i == 13)
			return 32'h1;
		return 32'h0;
	endfunction

	initial begin
		void'($urandom(32'h0923));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 48; i++)
			wait_reg(i[5:0], rst_val(i));
		wr(`VRS_REG_DEMAND, 32'h5);
		wait_reg(`VRS_REG_DEMAND, 32'h0);
		$display("test reset done");
		wr(`VRS_REG_RAMP_TYPE, {24'h0, `VRS_RAMP_JERK});
		wr(`VRS_REG_VL_ACC_DV, 32'h000F4240);
		wr(`VRS_REG_VL_DEC_DV, 32'h000F4240);
		wr(`VRS_REG_VL_QS_DV, 32'h000F4240);
		wr(`VRS_REG_VL_MAX, 32'h6);
		wr(`VRS_REG_VL_TARGET, 32'h7 + ($urandom % 8));
		wr(`VRS_REG_MODE, {24'h0, `VRS_MODE_VL});
		wr(`VRS_REG_CTRL, 32'h1);
		wait_reg(`VRS_REG_DEMAND, 32'h6);
		chk({31'h0, den}, 32'h1);
		chk(dem, 32'h6);
		wait_reg(`VRS_REG_ACTUAL, 32'h6);
		wait_reg(`VRS_REG_STATUS, 32'h800);
		wr(`VRS_REG_DIM_MUL, 32'h3);
		wr(`VRS_REG_DIM_DIV, 32'h2);
		wait_reg(`VRS_REG_VL_DEMAND, 32'h9);
		wr(`VRS_REG_MAX_MOTOR, 32'h3);
		wait_reg(`VRS_REG_DEMAND, 32'h3);
		wr(`VRS_REG_CTRL, 32'h101);
		wait_reg(`VRS_REG_DEMAND, 32'h0);
		wr(`VRS_REG_VL_MIN, 32'h2);
		wr(`VRS_REG_VL_TARGET, 32'h1);
		wr(`VRS_REG_CTRL, 32'h1);
		wait_reg(`VRS_REG_DEMAND, 32'h2);
		wr(`VRS_REG_CTRL, 32'h5);
		wait_reg(`VRS_REG_DEMAND, 32'h0);
		wr(`VRS_REG_MODE, 32'h0);
		wait_reg(`VRS_REG_DEMAND, 32'h0);
		chk({31'h0, den}, 32'h0);
		$display("test velocity done");
		wr(`VRS_REG_MAX_MOTOR, 32'h7FFFFFFF);
		wr(`VRS_REG_PROF_ACC, 32'h000F4240);
		wr(`VRS_REG_PROF_DEC, 32'h000F4240);
		for (int j = 0; j < 4; j++)
			wr(`VRS_REG_JERK1 + j[5:0], 32'h7FFFFFFF);
		wr(`VRS_REG_PV_TARGET, 32'h5);
		wr(`VRS_REG_POS_MAX, 32'h64);
		wr(`VRS_REG_CTRL, 32'h1);
		wr(`VRS_REG_MODE, {24'h0, `VRS_MODE_PV});
		wait_reg(`VRS_REG_ACTUAL, 32'h5);
		wait_reg(`VRS_REG_STATUS, 32'h400);
		wr(`VRS_REG_CTRL, 32'h101);
		wait_reg(`VRS_REG_ACTUAL, 32'h0);
		wait_reg(`VRS_REG_STATUS, 32'h1500);
		wr(`VRS_REG_RAMP_TYPE, 32'h0);
		slow <= 1'b1;
		wr(`VRS_REG_POLARITY, 32'h40);
		wr(`VRS_REG_CTRL, 32'h3);
		wait_reg(`VRS_REG_DEMAND, 32'hFFFFFFFB);
		wait_reg(`VRS_REG_STATUS, 32'h3000);
		slow <= 1'b0;
		wait_reg(`VRS_REG_ACTUAL, 32'hFFFFFFFB);
		wr(`VRS_REG_CTRL, 32'h0);
		bus(1'b0, `VRS_REG_POSITION, 32'h0, d);
		chk({31'h0, $signed(d) >= 0 && $signed(d) <= 100}, 32'h1);
		$display("test profile done");
		end_of_test();
	end
endmodule

`default_nettype wire
